// ==== act_pkg.sv ====
package act_pkg;
   // System clock
   localparam int unsigned CLK_MHZ      = 40;
   // Clock pin timing
   localparam int unsigned EXT_CLK_NS   = 250;
   localparam int unsigned EXT_HALF_CYC = EXT_CLK_NS * CLK_MHZ / 2000;
   localparam int unsigned OSC_HALF_CYC = EXT_HALF_CYC;
   localparam int unsigned FRESH_CYC    = EXT_CLK_NS * CLK_MHZ / 1000;
   localparam int unsigned GUARD_NS     = 20;
   localparam int unsigned GUARD_CYC    = (GUARD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned READ_CYC     = 4;
   localparam int unsigned CNT_W        = 16;
   // Converter word
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned BIT_W        = 3;
   localparam logic [DATA_W-1:0] HALF_SCALE = 8'h80;
   // Internal (divided) clock cycle plan, ten cycles per conversion
   localparam int unsigned CYC_W        = 4;
   localparam logic [CYC_W-1:0] HOLD_CYC  = 4'h1;
   localparam logic [CYC_W-1:0] FIRST_DEC = 4'h1;
   localparam logic [CYC_W-1:0] LAST_DEC  = 4'h8;
   localparam logic [CYC_W-1:0] END_CYC   = 4'h9;

   typedef enum logic [0:0] {
      DEV_IDLE = 1'b0,
      DEV_CONV = 1'b1
   } act_dev_state_type;

   typedef enum logic [2:0] {
      HST_IDLE  = 3'b000,
      HST_ALIGN = 3'b001,
      HST_READ  = 3'b010,
      HST_WAIT  = 3'b011,
      HST_CAPT  = 3'b100
   } act_host_state_type;
endpackage

// ==== act_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface act_link_if;
   import act_pkg::*;
   logic              cs_b;
   logic              rd_b;
   logic              busy_b;
   logic [DATA_W-1:0] data;
   logic              data_oe;
   logic              clk_dev;
   logic              clk_dev_oe;
   logic              clk_host;
   logic              clk_host_oe;
   logic              clk_pin;

   // Undriven clock pin floats to supply
   assign clk_pin = clk_dev_oe ? clk_dev : (clk_host_oe ? clk_host : 1'b1);

   modport dev (
      input  cs_b, rd_b, clk_pin,
      output busy_b, data, data_oe, clk_dev, clk_dev_oe
   );
   modport host (
      output cs_b, rd_b, clk_host, clk_host_oe,
      input  busy_b, data, data_oe, clk_pin
   );
endinterface
`default_nettype wire

// ==== act_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
module act_dev #(
   parameter int unsigned OSC_HALF  = act_pkg::OSC_HALF_CYC,
   parameter int unsigned FRESH_LEN = act_pkg::FRESH_CYC
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   // Processor link
   act_link_if.dev                         link,
   // Converter core
   input  wire logic                       comp_gt,
   input  wire logic                       use_int_osc,
   input  wire logic                       multi_sample,
   output logic                            sample_switch,
   output logic [act_pkg::DATA_W-1:0]      dac_code,
   output logic [act_pkg::DATA_W-1:0]      result
);
   import act_pkg::*;

   act_dev_state_type  state;
   act_dev_state_type  next_state;
   logic               req_q;
   logic               pin_q;
   logic               int_phase;
   logic [CYC_W-1:0]   int_cyc;
   logic               osc_lvl;
   logic [CNT_W-1:0]   osc_cnt;
   logic [CNT_W-1:0]   fresh_cnt;
   logic [DATA_W-1:0]  next_sar;
   logic [DATA_W-1:0]  next_result;
   logic               next_switch;

   function automatic logic [BIT_W-1:0] bit_of(input logic [CYC_W-1:0] cyc);
      logic [CYC_W-1:0] pos;
      pos = LAST_DEC - cyc;
      return pos[BIT_W-1:0];
   endfunction

   wire               req        = !link.cs_b && !link.rd_b;
   wire               converting = (state == DEV_CONV);
   wire               fresh      = (fresh_cnt != '0);
   wire               pin_fall   = pin_q && !link.clk_pin;
   // new read request starts a conversion
   wire               start      = req && !req_q && !converting && !fresh;
   // pin edges count only while converting
   wire               tick       = converting && pin_fall;
   // second pin fall completes a divided cycle
   wire               cyc_done   = tick && int_phase;
   wire               hold_edge  = tick && !int_phase && (int_cyc == HOLD_CYC);
   wire               decide     = cyc_done && (int_cyc >= FIRST_DEC) && (int_cyc <= LAST_DEC);
   wire               finish     = cyc_done && (int_cyc == END_CYC);
   wire [BIT_W-1:0]   bit_pos    = bit_of(int_cyc);
   wire               osc_wrap   = (osc_cnt == CNT_W'(OSC_HALF - 1));

   assign next_state  = start ? DEV_CONV : (finish ? DEV_IDLE : state);
   // output latch only moves at the end
   assign next_result = finish ? dac_code : result;

   // MSB first, next trial bit set
   always_comb begin
      next_sar = dac_code;
      if (start || finish) begin
         next_sar = HALF_SCALE;
      end else if (decide) begin
         next_sar[bit_pos] = comp_gt;
         if (bit_pos != '0) begin
            next_sar[bit_pos - 1'b1] = 1'b1;
         end
      end
   end

   always_comb begin
      next_switch = sample_switch;
      if (finish || !converting) begin
         next_switch = 1'b1;
      end else if (multi_sample) begin
         // open at each decision, reclose between
         if (decide) begin
            next_switch = 1'b0;
         end else if (tick && !int_phase) begin
            next_switch = 1'b1;
         end
      end else if (hold_edge) begin
         next_switch = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= DEV_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         req_q <= 1'b0;
         pin_q <= 1'b1;
      end else begin
         req_q <= req;
         pin_q <= link.clk_pin;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || start) begin
         int_phase <= 1'b0;
      end else if (tick) begin
         int_phase <= !int_phase;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || start) begin
         int_cyc <= '0;
      end else if (cyc_done) begin
         int_cyc <= int_cyc + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dac_code <= HALF_SCALE;
      end else begin
         dac_code <= next_sar;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sample_switch <= 1'b1;
      end else begin
         sample_switch <= next_switch;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         link.busy_b <= 1'b1;
      end else if (start) begin
         link.busy_b <= 1'b0;
      end else if (finish) begin
         link.busy_b <= 1'b1;
      end
   end

   // latch on the same edge as busy
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         result    <= '0;
         link.data <= '0;
      end else begin
         result    <= next_result;
         link.data <= next_result;
      end
   end

   // Data bus driven for every read, converting or not
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         link.data_oe <= 1'b0;
      end else begin
         link.data_oe <= req;
      end
   end

   // one pin period after busy release
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fresh_cnt <= '0;
      end else if (finish) begin
         fresh_cnt <= CNT_W'(FRESH_LEN);
      end else if (fresh) begin
         fresh_cnt <= fresh_cnt - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !converting || osc_wrap) begin
         osc_cnt <= '0;
      end else begin
         osc_cnt <= osc_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || !converting) begin
         osc_lvl <= 1'b1;
      end else if (osc_wrap) begin
         osc_lvl <= !osc_lvl;
      end
   end

   // Strap level is sampled, never loaded by the reset itself
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         link.clk_dev_oe <= 1'b0;
      end else begin
         link.clk_dev_oe <= use_int_osc;
      end
   end

   assign link.clk_dev = osc_lvl;
endmodule
`default_nettype wire

// ==== act_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module act_host #(
   parameter int unsigned EXT_HALF = act_pkg::EXT_HALF_CYC,
   parameter int unsigned READ_LEN = act_pkg::READ_CYC
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   // Converter link
   act_link_if.host                        link,
   // User side
   input  wire logic                       start,
   input  wire logic                       slow_mode,
   input  wire logic                       ext_clk_en,
   output logic [act_pkg::DATA_W-1:0]      result,
   output logic                            result_valid,
   output logic                            busy
);
   import act_pkg::*;

   act_host_state_type state;
   act_host_state_type next_state;
   logic [CNT_W-1:0]   ext_cnt;
   logic [CNT_W-1:0]   rd_cnt;
   logic               ext_lvl;

   wire ext_wrap = (ext_cnt == CNT_W'(EXT_HALF - 1));
   // request lands a guard time after a rise, or at once when ext_clk_en is low
   // request timed from the same clock as the pin
   wire aligned  = !ext_clk_en || (ext_lvl && ext_cnt == CNT_W'(GUARD_CYC - 1));
   wire rd_last  = (rd_cnt == CNT_W'(READ_LEN - 1));
   wire reading  = (next_state == HST_READ) || (next_state == HST_WAIT)
                   || (next_state == HST_CAPT);

   always_comb begin
      case (state)
         HST_IDLE:  next_state = start ? HST_ALIGN : HST_IDLE;
         HST_ALIGN: next_state = aligned ? HST_READ : HST_ALIGN;
         HST_READ:  next_state = !rd_last ? HST_READ : (slow_mode ? HST_WAIT : HST_CAPT);
         // Slow mode: read stretched until busy releases
         HST_WAIT:  next_state = link.busy_b ? HST_CAPT : HST_WAIT;
         HST_CAPT:  next_state = HST_IDLE;
         default:   next_state = HST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= HST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b || state != HST_READ) begin
         rd_cnt <= '0;
      end else begin
         rd_cnt <= rd_cnt + 1'b1;
      end
   end

   // a read drives both strobes low
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         link.cs_b <= 1'b1;
         link.rd_b <= 1'b1;
      end else begin
         link.cs_b <= !reading;
         link.rd_b <= !reading;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         result       <= '0;
         result_valid <= 1'b0;
         busy         <= 1'b0;
      end else begin
         result_valid <= (state == HST_CAPT);
         busy         <= !link.busy_b;
         if (state == HST_CAPT) begin
            result <= link.data;
         end
      end
   end

   // free-running pin clock at 50% duty
   always_ff @(posedge clk) begin
      if (!rst_b || !ext_clk_en || ext_wrap) begin
         ext_cnt <= '0;
      end else begin
         ext_cnt <= ext_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ext_lvl         <= 1'b1;
         link.clk_host_oe <= 1'b0;
      end else begin
         link.clk_host_oe <= ext_clk_en;
         if (!ext_clk_en) begin
            ext_lvl <= 1'b1;
         end else if (ext_wrap) begin
            ext_lvl <= !ext_lvl;
         end
      end
   end

   assign link.clk_host = ext_lvl;
endmodule
`default_nettype wire

// ==== act_link_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module act_link_monitor
   import act_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Link signals
   input  wire logic              cs_b,
   input  wire logic              rd_b,
   input  wire logic              busy_b,
   input  wire logic [DATA_W-1:0] data,
   input  wire logic              data_oe,
   input  wire logic              clk_dev,
   input  wire logic              clk_dev_oe,
   input  wire logic              clk_pin
);
   logic       pin_q;
   logic       rst_q;
   logic [4:0] falls;

   default clocking @(posedge clk); endclocking
   // Also masks the release edge, where reset values still show
   default disable iff (!rst_b || !rst_q);

   // Pin falls seen while converting; cleared whenever idle
   always_ff @(posedge clk) begin
      pin_q <= clk_pin;
      rst_q <= rst_b;
      if (!rst_b || busy_b) begin
         falls <= 5'h00;
      end else if (pin_q && !clk_pin) begin
         falls <= falls + 5'h01;
      end
   end

   property p_start;
      $fell(busy_b) |-> !$past(cs_b) && !$past(rd_b);
   endproperty
   a_start: assert property (p_start)
      else $error("busy asserted without a request");

   property p_len;
      $rose(busy_b) |-> falls == 5'h14;
   endproperty
   a_len: assert property (p_len)
      else $error("conversion did not last twenty pin cycles");

   property p_len_max;
      !busy_b |-> falls <= 5'h13;
   endproperty
   a_len_max: assert property (p_len_max)
      else $error("conversion ran past twenty pin cycles");

   property p_osc;
      busy_b && $past(busy_b) && clk_dev_oe |-> clk_dev;
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator not clamped high while idle");

   property p_latch;
      !$stable(data) |-> $rose(busy_b);
   endproperty
   a_latch: assert property (p_latch)
      else $error("data changed away from end of conversion");

   property p_oe;
      data_oe == (!$past(cs_b) && !$past(rd_b));
   endproperty
   a_oe: assert property (p_oe)
      else $error("data enable does not follow the read");

   property p_fresh;
      $rose(busy_b) |-> busy_b [*8];
   endproperty
   a_fresh: assert property (p_fresh)
      else $error("conversion restarted right after end");

   property p_pair;
      cs_b == rd_b;
   endproperty
   a_pair: assert property (p_pair)
      else $error("select and read strobe moved apart");

   property p_guard;
      $fell(cs_b) && busy_b |-> !($past(clk_pin) && !clk_pin);
   endproperty
   a_guard: assert property (p_guard)
      else $error("request landed on a pin falling edge");
endmodule
`default_nettype wire

// ==== act_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module act_tb;
   import act_pkg::*;
   logic        clk;
   logic        rst_b;
   logic        start;
   logic        slow_mode;
   logic        ext_clk_en;
   logic        comp_gt;
   logic        use_int_osc;
   logic        multi_sample;
   logic        sample_switch;
   logic        busy;
   logic        res_valid;
   logic        pin_q;
   logic        sw_q;
   logic [7:0]  dac_code;
   logic [7:0]  dev_res;
   logic [7:0]  res;
   logic [7:0]  ain;
   logic [7:0]  last;
   logic [31:0] seed;
   int          error_cnt;
   int          tests_run;
   int          nf;
   int          first;
   int          opens;

   act_link_if act_link_if_i ();
   act_dev act_dev_i (.clk, .rst_b, .link(act_link_if_i.dev), .comp_gt, .use_int_osc,
      .multi_sample, .sample_switch, .dac_code, .result(dev_res));
   act_host act_host_i (.clk, .rst_b, .link(act_link_if_i.host), .start, .slow_mode,
      .ext_clk_en, .result(res), .result_valid(res_valid), .busy);
   act_link_monitor act_link_monitor_i (.clk, .rst_b, .cs_b(act_link_if_i.cs_b),
      .rd_b(act_link_if_i.rd_b), .busy_b(act_link_if_i.busy_b), .data(act_link_if_i.data),
      .data_oe(act_link_if_i.data_oe), .clk_dev(act_link_if_i.clk_dev),
      .clk_dev_oe(act_link_if_i.clk_dev_oe), .clk_pin(act_link_if_i.clk_pin));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   // Expected code from a comparator that keeps bits at or below the input
   function automatic logic [7:0] sar(input logic [7:0] a);
      logic [7:0] c;
      c = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         if (a >= (c | (8'h01 << b))) begin
            c = c | (8'h01 << b);
         end
      end
      return c;
   endfunction

   task automatic summarize();
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic rd(input logic slow);
      int i;
      @(posedge clk);
      start <= 1'b1;
      slow_mode <= slow;
      @(posedge clk);
      start <= 1'b0;
      for (i = 0; i < 600 && res_valid !== 1'b1; i++) @(posedge clk);
      // Lost answer counts as a mismatch
      if (res_valid !== 1'b1) error_cnt++;
   endtask

   task automatic wait_idle(input int n);
      int i;
      for (i = 0; i < 400 && act_link_if_i.busy_b !== 1'b1; i++) @(posedge clk);
      if (act_link_if_i.busy_b !== 1'b1) error_cnt++;
      repeat (n) @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Comparator stand-in; one cycle of lag is harmless between decisions
   always @(posedge clk) comp_gt <= (ain >= dac_code);

   // Pin falls since start, and where the sampling switch opens
   always @(posedge clk) begin
      pin_q <= act_link_if_i.clk_pin;
      sw_q <= sample_switch;
      if (act_link_if_i.busy_b) begin
         nf <= 0;
      end else if (pin_q && !act_link_if_i.clk_pin) begin
         nf <= nf + 1;
      end
      if (sw_q && !sample_switch) begin
         opens <= opens + 1;
         if (opens == 0) first <= nf;
      end
   end

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      summarize();
   end

   initial begin
      int i;
      logic [31:0] r;
      rst_b = 1'b0;
      start = 1'b0;
      slow_mode = 1'b0;
      ext_clk_en = 1'b1;
      use_int_osc = 1'b0;
      multi_sample = 1'b0;
      comp_gt = 1'b0;
      ain = 8'h00;
      last = 8'h00;
      seed = 32'h27;
      error_cnt = 0;
      tests_run = 0;
      opens = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 16; i++) begin
         seed = xs(seed);
         r = seed;
         @(posedge clk);
         ain <= (i == 0) ? 8'hff : (i == 1) ? 8'h00 : r[15:8];
         ext_clk_en <= r[2];
         use_int_osc <= !r[2];
         multi_sample <= r[1];
         opens = 0;
         `CHK(sample_switch, 1'b1)
         rd(r[0]);
         `CHK(res, r[0] ? sar(ain) : last)
         wait_idle(FRESH_CYC + 2);
         last = sar(ain);
         `CHK(first, r[1] ? 4 : 3)
         `CHK(opens, r[1] ? 8 : 1)
         `CHK(sample_switch, 1'b1)
         `CHK(dev_res, last)
      end
      // Back-to-back reads on the internal oscillator
      ext_clk_en <= 1'b0;
      use_int_osc <= 1'b1;
      ain <= 8'h5a;
      rd(1'b0);
      `CHK(res, last)
      `CHK(busy, 1'b1)
      rd(1'b0);
      `CHK(res, last)
      wait_idle(0);
      last = sar(ain);
      rd(1'b0);
      `CHK(res, last)
      repeat (30) @(posedge clk);
      `CHK(act_link_if_i.busy_b, 1'b1)
      `CHK(busy, 1'b0)
      // Reset in mid conversion
      rd(1'b0);
      repeat (40) @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(dac_code, HALF_SCALE)
      rst_b <= 1'b1;
      rd(1'b1);
      `CHK(res, sar(ain))
      summarize();
   end
endmodule
`default_nettype wire
